// >>> hdl/cell_storage_reset.sv
// Purpose: Cell storage row: flop, three-state driver, latch bank, wide decode, resets
// Assumes: APB slave with zero wait states; user pins synchronous to ref_clk
// Notes: Lockout length is a parameter so simulation can shorten it
`timescale 1ns/10ps
`include "cell_storage_defs.svh"
module cell_storage_reset #(
   parameter int LOCKOUT_CYCLES = `LOCKOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic masterResetPin_n,
   output logic deviceReady,
   input wire logic userClk,
   input wire logic flopData,
   input wire logic flopClearIn,
   input wire logic flopPresetIn,
   output logic flopQ,
   input wire logic driverData,
   input wire logic driverEnable,
   output logic driverOut,
   output logic driverOe,
   input wire logic bankWrite,
   input wire logic [1:0] bankWriteSel,
   input wire logic [3:0] bankData,
   input wire logic bankReadEn,
   input wire logic [1:0] bankReadSel,
   output logic [3:0] bankOut,
   output logic bankOe,
   input wire logic [19:0] decodeIn,
   output logic decodeHit
);
   localparam logic [`SEQ_COUNT_W-1:0] GLOBAL_RESET_CONTROL_LAST = `SEQ_COUNT_W'(`GLOBAL_RESET_CONTROL_CYCLES - 1);
   localparam logic [`SEQ_COUNT_W-1:0] LOCK_LAST = `SEQ_COUNT_W'(LOCKOUT_CYCLES - 1);

   cell_storage_pkg::global_reset_control_state_t seqState;
   logic [`SEQ_COUNT_W-1:0] seqCount;
   logic lockPending;
   logic globalReset;
   logic active;
   logic [5:0] ctrl;
   logic [19:0] decodePol;
   logic swReset;
   logic setupRead;
   logic accessWrite;
   logic addrHit;
   logic [31:0] readMux;
   logic [1:0] variant;
   logic flopClk;
   logic masterOut;
   logic flopClear;
   logic flopSet;
   logic presetKind;
   logic drvOe;
   logic [3:0] bankMem [4];
   logic [4:0] andOut;
   logic locked;
   logic bankGate;

   function automatic logic regHit(input logic [7:0] addr);
      regHit = (addr == `CTRL_OFFSET) || (addr == `STATUS_OFFSET) ||
               (addr == `DECODE_POL_OFFSET);
   endfunction

   function automatic logic slotWrite(input logic gate, input logic [1:0] sel,
      input logic [1:0] slot);
      slotWrite = gate && (sel == slot);
   endfunction

   // APB decode
   assign setupRead = psel & ~penable & ~pwrite;
   assign accessWrite = psel & penable & pwrite;
   assign addrHit = regHit(paddr);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addrHit;
   assign swReset = accessWrite & (paddr == `CTRL_OFFSET) & pwdata[`CTRL_SW_RESET_BIT];

   // Control register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ctrl <= `CTRL_RESET;
      end else if (accessWrite && paddr == `CTRL_OFFSET) begin
         ctrl <= pwdata[`CTRL_DATA_INV_BIT:`CTRL_VARIANT_LSB];
      end
   end

   // Decode polarity register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         decodePol <= `DECODE_POL_RESET;
      end else if (accessWrite && paddr == `DECODE_POL_OFFSET) begin
         decodePol <= pwdata[19:0];
      end
   end

   // Register read mux
   always_comb begin
      readMux = 32'h00000000;
      if (paddr == `CTRL_OFFSET) begin
         readMux[`CTRL_DATA_INV_BIT:`CTRL_VARIANT_LSB] = ctrl;
      end else if (paddr == `STATUS_OFFSET) begin
         readMux[0] = globalReset;
         readMux[1] = locked;
         readMux[2] = flopQ;
         readMux[3] = decodeHit;
         readMux[4] = driverOe;
         readMux[8:5] = bankOut;
      end else if (paddr == `DECODE_POL_OFFSET) begin
         readMux[19:0] = decodePol;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prdata <= 32'h00000000;
      end else if (setupRead) begin
         prdata <= readMux;
      end
   end

   // Global reset and master reset sequencer
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         seqState <= cell_storage_pkg::GR_PULSE; // see RQ6
         seqCount <= '0;
         lockPending <= 1'b0;
      end else if (!masterResetPin_n) begin
         seqState <= cell_storage_pkg::GR_PULSE; // see RQ10
         seqCount <= '0;
         lockPending <= 1'b1; // see RQ11
      end else if (swReset && seqState == cell_storage_pkg::GR_RUN) begin
         seqState <= cell_storage_pkg::GR_PULSE;
         seqCount <= '0;
      end else begin
         unique case (seqState)
            cell_storage_pkg::GR_PULSE: begin
               if (seqCount == GLOBAL_RESET_CONTROL_LAST) begin
                  seqCount <= '0; // see RQ9
                  lockPending <= 1'b0;
                  seqState <= lockPending ? cell_storage_pkg::GR_LOCK
                                          : cell_storage_pkg::GR_RUN;
               end else begin
                  seqCount <= seqCount + 1'b1;
               end
            end
            cell_storage_pkg::GR_LOCK: begin
               if (seqCount == LOCK_LAST) begin
                  seqCount <= '0; // see RQ11
                  seqState <= cell_storage_pkg::GR_RUN;
               end else begin
                  seqCount <= seqCount + 1'b1;
               end
            end
            cell_storage_pkg::GR_RUN: begin
               seqCount <= '0;
            end
         endcase
      end
   end

   // Sequencer views
   assign globalReset = (seqState == cell_storage_pkg::GR_PULSE); // see RQ6 see RQ14
   assign active = (seqState == cell_storage_pkg::GR_RUN);
   assign deviceReady = active; // see RQ11
   assign locked = (seqState == cell_storage_pkg::GR_LOCK); // see RQ11

   // Bank write gate, closed only during lockout
   assign bankGate = bankWrite & ~locked; // see RQ8

   // Master-slave flop from two cascaded latch cells
   assign variant = ctrl[`CTRL_VARIANT_MSB-1:`CTRL_VARIANT_LSB-1];
   assign flopClk = userClk & active;
   assign flopClear = (variant == `VARIANT_CLEAR) & flopClearIn; // see RQ2
   assign flopSet = (variant == `VARIANT_PRESET) & flopPresetIn; // see RQ3
   assign presetKind = (variant == `VARIANT_PRESET); // see RQ7

   // Master latch cell
   config_logic_cell masterCell (
      .ref_clk(ref_clk),
      .srst(srst),
      .cfgMode(cell_storage_pkg::CELL_LATCH),
      .cfgInvert({2'b00, ~ctrl[`CTRL_EDGE_INV_BIT-1], ctrl[`CTRL_DATA_INV_BIT-1]}), // see RQ17
      .cfgCascade(1'b0),
      .pinIn({2'b00, flopClk, flopData}),
      .casIn(1'b0),
      .globalReset(globalReset),
      .resetValue(presetKind),
      .forceClear(flopClear),
      .forceSet(flopSet),
      .cellOut(),
      .casOut(masterOut),
      .outEnable()
   ); // see RQ1

   // Slave latch cell
   config_logic_cell slaveCell (
      .ref_clk(ref_clk),
      .srst(srst),
      .cfgMode(cell_storage_pkg::CELL_LATCH),
      .cfgInvert({2'b00, ctrl[`CTRL_EDGE_INV_BIT-1], 1'b0}), // see RQ17
      .cfgCascade(1'b1),
      .pinIn({2'b00, flopClk, 1'b0}),
      .casIn(masterOut),
      .globalReset(globalReset),
      .resetValue(presetKind),
      .forceClear(flopClear),
      .forceSet(flopSet),
      .cellOut(flopQ),
      .casOut(),
      .outEnable()
   ); // see RQ1 see RQ7

   // Gated output driver cell
   config_logic_cell driverCell (
      .ref_clk(ref_clk),
      .srst(srst),
      .cfgMode(cell_storage_pkg::CELL_TRI),
      .cfgInvert({2'b00, ctrl[`CTRL_DRV_EN_INV_BIT-1], ctrl[`CTRL_DRV_DATA_INV_BIT-1]}),
      .cfgCascade(1'b0),
      .pinIn({2'b00, driverEnable, driverData}),
      .casIn(1'b0),
      .globalReset(globalReset),
      .resetValue(1'b0),
      .forceClear(1'b0),
      .forceSet(1'b0),
      .cellOut(driverOut),
      .casOut(),
      .outEnable(drvOe)
   ); // see RQ4
   assign driverOe = drvOe & active;

   // Quad latch banks stacked as a register file
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < 4; i++) begin
            bankMem[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (slotWrite(bankGate, bankWriteSel, 2'(i))) begin
               bankMem[i] <= bankData; // see RQ5
            end else if (globalReset) begin
               bankMem[i] <= 4'h0; // see RQ8
            end
         end
      end
   end

   // Bank read path
   always_comb begin
      if (slotWrite(bankGate, bankWriteSel, bankReadSel)) begin
         bankOut = bankData; // see RQ8
      end else begin
         bankOut = bankMem[bankReadSel];
      end
   end
   assign bankOe = active & bankReadEn; // see RQ5

   // Twenty-input decode over cascade links
   for (genvar k = 0; k < 5; k++) begin : gAnd4
      config_logic_cell andCell (
         .ref_clk(ref_clk),
         .srst(srst),
         .cfgMode(cell_storage_pkg::CELL_AND),
         .cfgInvert(decodePol[4*k+3:4*k]),
         .cfgCascade(1'b0),
         .pinIn(decodeIn[4*k+3:4*k]),
         .casIn(1'b0),
         .globalReset(globalReset),
         .resetValue(1'b0),
         .forceClear(1'b0),
         .forceSet(1'b0),
         .cellOut(andOut[k]),
         .casOut(),
         .outEnable()
      ); // see RQ13
   end

   // Final cascaded AND
   config_logic_cell cascadeAnd (
      .ref_clk(ref_clk),
      .srst(srst),
      .cfgMode(cell_storage_pkg::CELL_AND),
      .cfgInvert(4'h0),
      .cfgCascade(1'b1),
      .pinIn(andOut[3:0]),
      .casIn(andOut[4]),
      .globalReset(globalReset),
      .resetValue(1'b0),
      .forceClear(1'b0),
      .forceSet(1'b0),
      .cellOut(decodeHit),
      .casOut(),
      .outEnable()
   ); // see RQ12 see RQ13
endmodule

// >>> hdl/cell_storage_defs.svh
// Purpose: Offsets, fields, reset values and timing counts of the cell storage block
// Assumes: 50 MHz ref_clk, 32-bit APB, byte addresses
// Notes: Definitions only
//
// Behaviour
// RQ1: A flip-flop is two cascaded cells, master latch then slave latch.
// RQ2: Clearing flop has an asynchronous clear that overrides clocking, forcing zero.
// RQ3: Presetting flop has an asynchronous preset overriding data, forcing one.
// RQ4: A cell input gates a three-state driver; data and enable polarity configurable.
// RQ5: Four latches with three-state output form a register-file slice; slices stack.
// RQ6: Global reset reaches every latch and flop without user routing, at power-up.
// RQ7: During global reset presetting flops go to one, all others to zero.
// RQ8: Global reset clears a latch only while holding; transparent latches pass data.
// RQ9: A global reset operation completes within 100 ns.
// RQ10: Master reset pin low restarts the power-on reset sequence.
// RQ11: After master reset the device stays locked out for several milliseconds.
// RQ12: Each cell has a cascade input and output on dedicated neighbour links.
// RQ13: Five AND4 cells feeding a cascaded AND4 give a twenty-input decode.
// RQ14: Flop reset comes from the dedicated global reset, never user routing.
// RQ15: A latch is transparent while its gate is high; gate and data polarity set.
// RQ16: A clearing latch adds asynchronous clear; all latches obey global reset.
// RQ17: The flop captures data at the clock edge; master open before, slave after.
`ifndef CELL_STORAGE_DEFS_SVH
`define CELL_STORAGE_DEFS_SVH

`define CTRL_OFFSET 8'h00
`define STATUS_OFFSET 8'h04
`define DECODE_POL_OFFSET 8'h08

`define CTRL_SW_RESET_BIT 0
`define CTRL_VARIANT_LSB 1
`define CTRL_VARIANT_MSB 2
`define CTRL_DRV_DATA_INV_BIT 3
`define CTRL_DRV_EN_INV_BIT 4
`define CTRL_EDGE_INV_BIT 5
`define CTRL_DATA_INV_BIT 6
`define CTRL_RESET 6'h00
`define DECODE_POL_RESET 20'h00000

`define VARIANT_CLEAR 2'h1
`define VARIANT_PRESET 2'h2

`define REF_CLK_PERIOD_NS 20
`define GLOBAL_RESET_CONTROL_TIME_NS 100
`define GLOBAL_RESET_CONTROL_CYCLES ((`GLOBAL_RESET_CONTROL_TIME_NS / `REF_CLK_PERIOD_NS) < 1 ? 1 : \
   (`GLOBAL_RESET_CONTROL_TIME_NS / `REF_CLK_PERIOD_NS))
`define LOCKOUT_TIME_MS 5
`define LOCKOUT_CYCLES ((`LOCKOUT_TIME_MS * 1000000) / `REF_CLK_PERIOD_NS)
`define SEQ_COUNT_W 18

`endif

// >>> hdl/cell_storage_pkg.sv
// Purpose: Types shared by the cell storage block
// Assumes: Constants live in cell_storage_defs.svh
// Notes: None
package cell_storage_pkg;
   typedef enum logic [1:0] {CELL_AND, CELL_SOP, CELL_LATCH, CELL_TRI} cell_mode_t;
   typedef enum {GR_PULSE, GR_LOCK, GR_RUN} global_reset_control_state_t;
endpackage

// >>> hdl/config_logic_cell.sv
// Purpose: One programmable logic cell: AND, sum of products, latch or three-state
// Assumes: All inputs synchronous to ref_clk
// Notes: Latch transparency is a combinational pass; holding state is a flop
`timescale 1ns/10ps
module config_logic_cell (
   input wire logic ref_clk,
   input wire logic srst,
   input wire cell_storage_pkg::cell_mode_t cfgMode,
   input wire logic [3:0] cfgInvert,
   input wire logic cfgCascade,
   input wire logic [3:0] pinIn,
   input wire logic casIn,
   input wire logic globalReset,
   input wire logic resetValue,
   input wire logic forceClear,
   input wire logic forceSet,
   output logic cellOut,
   output logic casOut,
   output logic outEnable
);
   logic [3:0] pin;
   logic gate;
   logic data;
   logic held;

   // Free input inversion
   assign pin = pinIn ^ cfgInvert; // see RQ4 see RQ15
   assign gate = pin[1];
   assign data = cfgCascade ? casIn : pin[0]; // see RQ12

   // Latch holding state
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         held <= 1'b0;
      end else if (cfgMode == cell_storage_pkg::CELL_LATCH) begin
         if (forceClear) begin
            held <= 1'b0; // see RQ2 see RQ16
         end else if (forceSet) begin
            held <= 1'b1; // see RQ3
         end else if (gate) begin
            held <= data; // see RQ15
         end else if (globalReset) begin
            held <= resetValue; // see RQ8 see RQ16
         end
      end
   end

   always_comb begin
      cellOut = 1'b0;
      outEnable = 1'b1;
      unique case (cfgMode)
         cell_storage_pkg::CELL_AND: begin
            cellOut = (&pin) & (~cfgCascade | casIn); // see RQ13
         end
         cell_storage_pkg::CELL_SOP: begin
            cellOut = (pin[0] & pin[1]) | (pin[2] & pin[3]) | (cfgCascade & casIn);
         end
         cell_storage_pkg::CELL_LATCH: begin
            if (forceClear) begin
               cellOut = 1'b0; // see RQ2
            end else if (forceSet) begin
               cellOut = 1'b1; // see RQ3
            end else if (gate) begin
               cellOut = data; // see RQ8 see RQ15
            end else begin
               cellOut = held;
            end
         end
         cell_storage_pkg::CELL_TRI: begin
            cellOut = pin[0]; // see RQ4
            outEnable = pin[1];
         end
      endcase
   end

   assign casOut = cellOut; // see RQ12
endmodule

// >>> tb/cell_storage_reset_monitor.sv
// Purpose: Port assertions for cell_storage_reset
// Assumes: Bound into every cell_storage_reset instance
// Notes: Tracks decode polarity from APB writes
`timescale 1ns/10ps
`include "cell_storage_defs.svh"
module cell_storage_reset_monitor #(
   parameter int LOCKOUT_CYCLES = `LOCKOUT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic masterResetPin_n,
   input wire logic deviceReady,
   input wire logic userClk,
   input wire logic flopClearIn,
   input wire logic flopPresetIn,
   input wire logic flopQ,
   input wire logic driverOe,
   input wire logic bankReadEn,
   input wire logic bankOe,
   input wire logic [19:0] decodeIn,
   input wire logic decodeHit
);
   logic [19:0] decPol;
   logic [1:0] varSh;
   logic mrSeen;
   int lockCnt;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Decode polarity and flop variant shadows
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         decPol <= '0;
         varSh <= '0;
      end else if (psel && penable && pwrite && pready) begin
         if (paddr == `DECODE_POL_OFFSET) begin
            decPol <= pwdata[19:0];
         end
         if (paddr == `CTRL_OFFSET) begin
            varSh <= pwdata[`CTRL_VARIANT_MSB:`CTRL_VARIANT_LSB];
         end
      end
   end
   // Cycles from master reset release to ready
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         lockCnt <= 0;
         mrSeen <= 1'b0;
      end else if (!masterResetPin_n) begin
         lockCnt <= 0;
         mrSeen <= 1'b1;
      end else if (deviceReady) begin
         mrSeen <= 1'b0;
      end else if (mrSeen) begin
         lockCnt <= lockCnt + 1;
      end
   end
   AST_CLEAR_FORCES_ZERO: assert property (
      flopClearIn && varSh == `VARIANT_CLEAR |-> !flopQ) else $error("clear did not force zero");
   AST_PRESET_FORCES_ONE: assert property (
      flopPresetIn && varSh == `VARIANT_PRESET |-> flopQ) else $error("preset did not force one");
   AST_OUTPUTS_LOCKED: assert property (
      !deviceReady |-> !driverOe && !bankOe) else $error("output enabled while locked");
   AST_MR_RESTARTS: assert property (
      !masterResetPin_n |=> !deviceReady) else $error("ready during master reset");
   AST_LOCKOUT_LENGTH: assert property (
      $rose(deviceReady) && mrSeen |-> lockCnt >= LOCKOUT_CYCLES) else $error("lockout short");
   AST_GLOBAL_RESET_CONTROL_BOUNDED: assert property (
      $fell(srst) |-> ##[1:8] deviceReady) else $error("global reset too long");
   AST_DECODE_AND: assert property (
      decodeHit == &(decodeIn ^ decPol)) else $error("decode mismatch");
   AST_BANK_OE: assert property (
      bankOe == (bankReadEn && deviceReady)) else $error("bank enable mismatch");
   AST_FLOP_HOLD: assert property (
      userClk && $past(userClk) && $past(userClk, 2) && deviceReady && $past(deviceReady, 2)
      && !(flopClearIn || flopPresetIn) && !$past(flopClearIn || flopPresetIn)
      |-> $stable(flopQ)) else $error("flop changed while clock high");
endmodule
bind cell_storage_reset cell_storage_reset_monitor #(.LOCKOUT_CYCLES(LOCKOUT_CYCLES)) mon (
   .ref_clk(ref_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .masterResetPin_n(masterResetPin_n),
   .deviceReady(deviceReady), .userClk(userClk), .flopClearIn(flopClearIn),
   .flopPresetIn(flopPresetIn), .flopQ(flopQ), .driverOe(driverOe), .bankReadEn(bankReadEn),
   .bankOe(bankOe), .decodeIn(decodeIn), .decodeHit(decodeHit)
);

// >>> tb/board_reset_source.sv
// Purpose: Board reset source driving the master reset pin
// Assumes: Request pulse is one cycle
// Notes: Low time is a parameter
`timescale 1ns/10ps
module board_reset_source #(
   parameter int LOW_CYCLES = 3
) (
   input wire logic ref_clk,
   input wire logic pulseReq,
   output logic masterResetPin_n
);
   int lowCnt = 0;
   // Holds the pin low, then leaves the device alone
   always_ff @(posedge ref_clk) begin
      if (pulseReq) begin
         lowCnt <= LOW_CYCLES;
      end else if (lowCnt > 0) begin
         lowCnt <= lowCnt - 1;
      end
   end
   assign masterResetPin_n = (lowCnt == 0);
endmodule

// >>> tb/cell_storage_reset_test.sv
// Purpose: Self-checking bench for cell_storage_reset
// Assumes: Zero wait APB, shortened lockout
// Notes: Bench model uses integer arrays
`timescale 1ns/10ps
`include "cell_storage_defs.svh"
module cell_storage_reset_test;
   localparam int LOCK = 20;
   logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, masterResetPin_n, deviceReady;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed, r;
   logic userClk, flopData, flopClearIn, flopPresetIn, flopQ, driverData, driverEnable;
   logic driverOut, driverOe, bankWrite, bankReadEn, bankOe, decodeHit, pulseReq, err;
   logic [1:0] bankWriteSel, bankReadSel;
   logic [3:0] bankData, bankOut;
   logic [19:0] decodeIn;
   int failures, numChecks, n;
   int bankModel[4];
   cell_storage_reset #(.LOCKOUT_CYCLES(LOCK)) dut (.ref_clk(ref_clk), .srst(srst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .masterResetPin_n(masterResetPin_n),
      .deviceReady(deviceReady), .userClk(userClk), .flopData(flopData),
      .flopClearIn(flopClearIn), .flopPresetIn(flopPresetIn), .flopQ(flopQ),
      .driverData(driverData), .driverEnable(driverEnable), .driverOut(driverOut),
      .driverOe(driverOe), .bankWrite(bankWrite), .bankWriteSel(bankWriteSel),
      .bankData(bankData), .bankReadEn(bankReadEn), .bankReadSel(bankReadSel),
      .bankOut(bankOut), .bankOe(bankOe), .decodeIn(decodeIn), .decodeHit(decodeHit));
   board_reset_source src (.ref_clk(ref_clk), .pulseReq(pulseReq),
      .masterResetPin_n(masterResetPin_n));
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task waitReady;
      n = 0;
      while (deviceReady !== 1'b1) begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task capture(input logic d);
      @(posedge ref_clk);
      {flopData, userClk} <= {d, 1'b0};
      @(posedge ref_clk);
      userClk <= 1'b1;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task bankCheck;
      for (int s = 0; s < 4; s++) begin
         @(posedge ref_clk);
         {bankReadEn, bankReadSel} <= {1'b1, 2'(s)};
         @(negedge ref_clk);
         chk("bankOut", 32'(bankOut), 32'(bankModel[s]));
         chk("bankOe", 32'(bankOe), 32'h1);
      end
   endtask
   initial begin
      seed = 32'h1A81;
      {failures, numChecks} = '0;
      srst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, pulseReq} = '0;
      {userClk, flopData, flopClearIn, flopPresetIn, driverData, driverEnable} = '0;
      {bankWrite, bankWriteSel, bankData, bankReadEn, bankReadSel, decodeIn} = '0;
      bankModel = '{0, 0, 0, 0};
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      waitReady();
      chk("readyDelay", 32'(n <= `GLOBAL_RESET_CONTROL_CYCLES + 3), 32'h1);
      chk("flopQ", 32'(flopQ), 32'h0);
      bankCheck();
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk("ctrl", rd, 32'h0);
      apb(1'b0, `DECODE_POL_OFFSET, 32'h0);
      chk("decodePol", rd, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmappedErr", 32'(err), 32'h1);
      chk("unmappedData", rd, 32'h0);
      apb(1'b1, `CTRL_OFFSET, 32'h44);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk("ctrlBack", rd, 32'h44);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, `CTRL_OFFSET, 32'(i % 2) << 6);
         r = rnd();
         capture(r[0]);
         chk("flopQ", 32'(flopQ), 32'(r[0] ^ i[0]));
      end
      for (int s = 0; s < 4; s++) begin
         r = rnd();
         @(posedge ref_clk);
         {bankWrite, bankWriteSel, bankData} <= {1'b1, 2'(s), r[3:0]};
         @(posedge ref_clk);
         bankWrite <= 1'b0;
         bankModel[s] = int'(r[3:0]);
      end
      bankCheck();
      for (int v = 1; v < 3; v++) begin
         apb(1'b1, `CTRL_OFFSET, 32'(v) << 1);
         capture(v == 1);
         @(posedge ref_clk);
         {flopClearIn, flopPresetIn} <= {v == 1, v == 2};
         @(negedge ref_clk);
         chk("flopForced", 32'(flopQ), 32'(v == 2));
         @(posedge ref_clk);
         {flopClearIn, flopPresetIn} <= 2'b00;
         @(negedge ref_clk);
         chk("flopAfter", 32'(flopQ), 32'(v == 2));
      end
      capture(1'b0);
      @(posedge ref_clk);
      userClk <= 1'b0;
      apb(1'b1, `CTRL_OFFSET, 32'h05);
      repeat (2) @(posedge ref_clk);
      waitReady();
      @(negedge ref_clk);
      chk("flopPreset", 32'(flopQ), 32'h1);
      bankModel = '{0, 0, 0, 0};
      bankCheck();
      apb(1'b1, `CTRL_OFFSET, 32'h02);
      @(posedge ref_clk);
      {pulseReq, driverEnable} <= 2'b11;
      @(posedge ref_clk);
      pulseReq <= 1'b0;
      @(posedge ref_clk);
      while (masterResetPin_n !== 1'b1) begin
         @(posedge ref_clk);
      end
      chk("lockedOe", 32'(driverOe), 32'h0);
      waitReady();
      chk("lockout", 32'(n), 32'(LOCK + `GLOBAL_RESET_CONTROL_CYCLES));
      @(negedge ref_clk);
      chk("flopMr", 32'(flopQ), 32'h0);
      bankCheck();
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      chk("status", rd, (32'(bankModel[3]) << 5) | 32'h10);
      for (int i = 0; i < 16; i++) begin
         if (i % 4 == 0) apb(1'b1, `CTRL_OFFSET, 32'(i / 4) << 3);
         r = rnd();
         @(posedge ref_clk);
         {driverData, driverEnable} <= r[1:0];
         @(negedge ref_clk);
         chk("driverOut", 32'(driverOut), 32'(r[1] ^ i[2]));
         chk("driverOe", 32'(driverOe), 32'(r[0] ^ i[3]));
      end
      for (int i = 0; i < 6; i++) begin
         r = rnd();
         apb(1'b1, `DECODE_POL_OFFSET, {12'h000, r[19:0]});
         @(posedge ref_clk);
         decodeIn <= ~r[19:0];
         @(negedge ref_clk);
         chk("decodeHit", 32'(decodeHit), 32'h1);
         @(posedge ref_clk);
         decodeIn <= ~r[19:0] ^ (20'h00001 << (rnd() % 20));
         @(negedge ref_clk);
         chk("decodeMiss", 32'(decodeHit), 32'h0);
      end
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      tally_and_finish();
   end
endmodule
